// ---- rtl/interrupt_vector_dispatch.sv ----
/*
 Reset and interrupt vector address generation for an 8-bit core.
 Assumes peripheral requests are synchronous levels on clk_sys and that
 the core acknowledges a dispatch with irq_ack in the cycle it loads it.
*/
// What this block does
// - All reset causes share one reset vector, at word zero by default.
// - Enhanced stage capture, end and enhanced end use offsets 1 to 3.
// - Reduced stage capture, end and enhanced end use offsets 4 to 6.
// - Comparators zero, one and two use offsets 7, 8 and 9.
// - External requests zero, one and two use offsets 10, 14 and 16.
// - Timer capture uses 11, timer overflow 12, converter done 13.
// - Serial transfer complete uses offset 15.
// - Watchdog, eeprom ready and self-program done use 17, 18, 19.
// - With table select set, each vector is offset plus boot start.
// - With the boot fuse programmed, resets start at the boot address.
// - Reset address and table base follow fuse and select separately.
// - Fuse value one means unprogrammed and zero means programmed.
// - Hardware clears unlock after four cycles or on the select write.
// - Dispatch is held off in the window and one cycle past select.
`timescale 1ns/1ps
module interrupt_vector_dispatch #(
    parameter logic [11:0] BOOT_RESET_ADDR =
        vector_pkg::BOOT_RESET_ADDR_DEFAULT
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic boot_reset_fuse,
    input wire logic global_irq_enable,
    input wire logic [vector_pkg::SRC_N-1:0] irq_request,
    input wire logic irq_ack,
    input wire vector_pkg::reg_req_type reg_req,
    output logic [7:0] reg_rdata,
    output logic [vector_pkg::ADDR_W-1:0] reset_vector,
    output vector_pkg::dispatch_type dispatch
);
    import vector_pkg::*;

    // ==========================================================
    // Source order: index i sits at table offset i plus one
    // ==========================================================
    // 0..2 enhanced stage, 3..5 reduced stage, 6..8 comparators,
    // 9 ext0, 10 timer capture, 11 timer overflow, 12 converter,
    // 13 ext1, 14 serial, 15 ext2, 16 watchdog, 17 eeprom, 18 spm.

    logic unlocked;
    logic select;
    logic block_irq;
    logic ctrl_write;
    logic found;
    logic [4:0] pick;
    logic [SRC_N-1:0] enable;
    logic [SRC_N-1:0] next_enable;
    logic [7:0] next_rdata;
    logic fuse_seen;
    logic next_fuse_seen;
    logic [ADDR_W-1:0] next_reset_vector;
    dispatch_type next_dispatch;

    assign ctrl_write = reg_req.wr && (reg_req.addr == CORE_CTRL_OFFSET);

    vector_unlock unlock_seq (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .ctrl_write(ctrl_write),
        .ctrl_wdata(reg_req.wdata),
        .unlocked(unlocked),
        .select(select),
        .block_irq(block_irq)
    );

    priority_pick picker (
        .pending(irq_request & enable),
        .found(found),
        .index(pick)
    );

    // ==========================================================
    // Reset vector, fuse caught after reset release
    // ==========================================================
    always_comb begin
        next_fuse_seen = 1'b1;
        next_reset_vector = reset_vector;
        if (!fuse_seen) begin
            // A low fuse is programmed.
            next_reset_vector = boot_reset_fuse ? RESET_ADDR
                                                : BOOT_RESET_ADDR;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            fuse_seen <= 1'b0;
            reset_vector <= RESET_ADDR;
        end else begin
            fuse_seen <= next_fuse_seen;
            reset_vector <= next_reset_vector;
        end
    end

    // ==========================================================
    // Dispatch
    // ==========================================================
    always_comb begin
        next_dispatch = dispatch;
        if (dispatch.valid && irq_ack) begin
            next_dispatch.valid = 1'b0;
        end else if (!dispatch.valid && found && global_irq_enable
                     && !block_irq) begin
            next_dispatch.valid = 1'b1;
            next_dispatch.index = pick;
            // Table base follows select only, never the fuse.
            if (select) begin
                next_dispatch.addr = BOOT_RESET_ADDR
                    + vector_offset(pick);
            end else begin
                next_dispatch.addr = vector_offset(pick);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            dispatch <= '0;
        end else begin
            dispatch <= next_dispatch;
        end
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_comb begin
        next_enable = enable;
        next_rdata = 8'h00;
        if (reg_req.wr) begin
            case (reg_req.addr)
                PENDING_LO_OFFSET: next_enable[7:0] = reg_req.wdata;
                PENDING_MID_OFFSET: next_enable[15:8] = reg_req.wdata;
                PENDING_HI_OFFSET: next_enable[18:16] = reg_req.wdata[2:0];
                default: next_enable = enable;
            endcase
        end
        if (reg_req.rd) begin
            case (reg_req.addr)
                CORE_CTRL_OFFSET:
                    next_rdata = {6'h00, select, unlocked};
                PENDING_LO_OFFSET: next_rdata = enable[7:0];
                PENDING_MID_OFFSET: next_rdata = enable[15:8];
                PENDING_HI_OFFSET: next_rdata = {5'h00, enable[18:16]};
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            enable <= '0;
            reg_rdata <= 8'h00;
        end else begin
            enable <= next_enable;
            reg_rdata <= next_rdata;
        end
    end
endmodule // interrupt_vector_dispatch

// ---- rtl/priority_pick.sv ----
/*
 Fixed-priority picker: lowest index of the pending requests wins.
 Assumes requests and enables come from logic on the same clock.
*/
`timescale 1ns/1ps
module priority_pick (
    input wire logic [vector_pkg::SRC_N-1:0] pending,
    output logic found,
    output logic [4:0] index
);
    import vector_pkg::*;

    // ==========================================================
    // Lowest index first
    // ==========================================================
    always_comb begin
        found = 1'b0;
        index = 5'h00;
        for (int i = SRC_N - 1; i >= 0; i--) begin
            if (pending[i]) begin
                found = 1'b1;
                index = 5'(i);
            end
        end
    end
endmodule // priority_pick

// ---- rtl/vector_pkg.sv ----
/*
 Shared constants and types for the interrupt vector dispatch block.
 Assumes a single core clock and a synchronous active-low reset.
*/
package vector_pkg;

    // ==========================================================
    // Widths and counts
    // ==========================================================
    localparam int ADDR_W = 12;
    localparam int SRC_N = 19;
    localparam int REG_AW = 4;
    localparam logic [2:0] UNLOCK_CYCLES = 3'h4;

    // ==========================================================
    // Addresses
    // ==========================================================
    localparam logic [ADDR_W-1:0] RESET_ADDR = 12'h000;
    localparam logic [ADDR_W-1:0] TABLE_BASE = 12'h001;
    localparam logic [ADDR_W-1:0] BOOT_RESET_ADDR_DEFAULT = 12'hC00;

    // ==========================================================
    // Register map and control bit positions
    // ==========================================================
    localparam logic [REG_AW-1:0] CORE_CTRL_OFFSET = 4'h0;
    localparam logic [REG_AW-1:0] PENDING_LO_OFFSET = 4'h1;
    localparam logic [REG_AW-1:0] PENDING_MID_OFFSET = 4'h2;
    localparam logic [REG_AW-1:0] PENDING_HI_OFFSET = 4'h3;
    localparam int UNLOCK_BIT = 0;
    localparam int SELECT_BIT = 1;
    localparam logic [7:0] CORE_CTRL_RESET = 8'h00;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic [REG_AW-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] addr;
        logic [4:0] index;
    } dispatch_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_UNLOCKED = 2'b01,
        ST_HOLD = 2'b10
    } unlock_state_type;

    // Vector offset of source index i is i plus one.
    function automatic logic [ADDR_W-1:0] vector_offset(
        input logic [4:0] index);
        vector_offset = {7'h00, index} + TABLE_BASE;
    endfunction

endpackage

// ---- rtl/vector_unlock.sv ----
/*
 Timed unlock sequence for the vector table select bit.
 Assumes register writes arrive as one-cycle strobes on the core clock.
*/
`timescale 1ns/1ps
module vector_unlock (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ctrl_write,
    input wire logic [7:0] ctrl_wdata,
    output logic unlocked,
    output logic select,
    output logic block_irq
);
    import vector_pkg::*;

    unlock_state_type state;
    unlock_state_type next_state;
    logic [2:0] count;
    logic [2:0] next_count;
    logic next_select;

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        next_state = state;
        next_count = count;
        next_select = select;
        case (state)
            ST_IDLE: begin
                if (ctrl_write && ctrl_wdata[UNLOCK_BIT]) begin
                    next_state = ST_UNLOCKED;
                    next_count = 3'h1;
                end
            end
            ST_UNLOCKED: begin
                next_count = count + 3'h1;
                if (ctrl_write && !ctrl_wdata[UNLOCK_BIT]) begin
                    next_select = ctrl_wdata[SELECT_BIT];
                    next_state = ST_HOLD;
                end else if (count >= UNLOCK_CYCLES) begin
                    next_state = ST_IDLE;
                end
            end
            ST_HOLD: begin
                // The instruction after the select write still runs blind.
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state <= ST_IDLE;
            count <= 3'h0;
            select <= CORE_CTRL_RESET[SELECT_BIT];
        end else begin
            state <= next_state;
            count <= next_count;
            select <= next_select;
        end
    end

    assign unlocked = (state == ST_UNLOCKED);
    // The global enable flag is untouched; only dispatch is held off.
    assign block_irq = (state != ST_IDLE);
endmodule // vector_unlock

// ---- sim/core_model.sv ----
/* Core-side model that loads each dispatch and acknowledges it.
   Assumes the dispatch carrier of vector_pkg on the same clock. */
`timescale 1ns/1ps
module core_model (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic slow,
    input wire vector_pkg::dispatch_type dispatch,
    output logic irq_ack
);
    import vector_pkg::*;
    logic [1:0] wait_cnt;
    // A slow core lets the vector stand, so holding is really exercised.
    always_ff @(posedge clk_sys) begin
        if (!nrst || !dispatch.valid || irq_ack) begin
            wait_cnt <= 2'h0;
            irq_ack <= 1'b0;
        end else begin
            wait_cnt <= wait_cnt + 2'h1;
            irq_ack <= !slow || wait_cnt == 2'h2;
        end
    end
endmodule // core_model

// ---- sim/interrupt_vector_dispatch_tb.sv ----
/* Self-checking bench for interrupt_vector_dispatch.
   Assumes the core model and the bound checker beside the design. */
`timescale 1ns/1ps
module interrupt_vector_dispatch_tb;
    import vector_pkg::*;
    localparam logic [11:0] BOOT = 12'hC00;
    typedef struct packed {logic [18:0] req; logic [11:0] addr;} row_type;
    logic clk_sys, nrst, boot_reset_fuse, global_irq_enable, irq_ack, slow;
    logic [SRC_N-1:0] irq_request;
    reg_req_type reg_req;
    logic [7:0] reg_rdata;
    logic [ADDR_W-1:0] reset_vector;
    dispatch_type dispatch;
    logic [11:0] off;
    int miscompares = 0, n_checks = 0, cycles = 0;
    row_type rows [22];
    logic [11:0] tab [19] = '{12'h001, 12'h002, 12'h003,
        12'h004, 12'h005, 12'h006, 12'h007, 12'h008, 12'h009,
        12'h00A, 12'h00B, 12'h00C, 12'h00D, 12'h00E, 12'h00F,
        12'h010, 12'h011, 12'h012, 12'h013};
    interrupt_vector_dispatch #(.BOOT_RESET_ADDR(BOOT)) dut_u (
        .clk_sys(clk_sys), .nrst(nrst), .boot_reset_fuse(boot_reset_fuse),
        .global_irq_enable(global_irq_enable), .irq_request(irq_request),
        .irq_ack(irq_ack), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .reset_vector(reset_vector), .dispatch(dispatch));
    core_model core_u (.clk_sys(clk_sys), .nrst(nrst), .slow(slow),
        .dispatch(dispatch), .irq_ack(irq_ack));
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys) reg_req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_sys) reg_req <= '0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_sys) reg_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_sys) reg_req <= '0;
        #1 chk({4'h0, reg_rdata}, {4'h0, e});
    endtask
    // Waits a bounded time, then lets the core acknowledge and settle.
    task automatic wait_chk(input logic [11:0] e, input logic [11:0] base);
        int n;
        n = 0;
        do @(negedge clk_sys) n++; while (!dispatch.valid && n < 20);
        chk(dispatch.valid ? dispatch.addr : 12'hFFF, e + base);
        chk({7'h00, dispatch.index} + 12'h001, e);
        @(posedge clk_sys) irq_request <= '0;
        repeat (5) @(posedge clk_sys);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            close_out();
        end
    end
    initial begin
        nrst = 1'b0;
        boot_reset_fuse = 1'b1;
        global_irq_enable = 1'b0;
        irq_request = '0;
        reg_req = '0;
        slow = 1'b0;
        for (int i = 0; i < 19; i++)
            rows[i] = '{19'h1 << i, tab[i]};
        rows[19] = '{19'h7FFFF, 12'h001};
        rows[20] = '{19'h40C00, 12'h00B};
        rows[21] = '{19'h60000, 12'h012};
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
        rd(CORE_CTRL_OFFSET, CORE_CTRL_RESET);
        rd(PENDING_LO_OFFSET, 8'h00);
        wr(4'h4, 8'hFF);
        rd(4'h4, 8'h00);
        chk(reset_vector, 12'h000);
        wr(PENDING_LO_OFFSET, 8'hFF);
        wr(PENDING_MID_OFFSET, 8'hFF);
        wr(PENDING_HI_OFFSET, 8'h07);
        @(posedge clk_sys) global_irq_enable <= 1'b1;
        for (int s = 0; s < 2; s++) begin
            off = s ? BOOT : 12'h000;
            for (int i = 0; i < 22; i++) begin
                @(posedge clk_sys) irq_request <= rows[i].req;
                wait_chk(rows[i].addr, off);
            end
            if (s == 0) begin
                wr(PENDING_LO_OFFSET, 8'hFE);
                @(posedge clk_sys) irq_request <= 19'h00003;
                wait_chk(12'h002, 12'h000);
                wr(PENDING_LO_OFFSET, 8'hFF);
                @(posedge clk_sys) global_irq_enable <= 1'b0;
                irq_request <= 19'h00004;
                repeat (3) @(negedge clk_sys)
                    chk({11'h000, dispatch.valid}, 12'h000);
                @(posedge clk_sys) global_irq_enable <= 1'b1;
                wait_chk(12'h003, 12'h000);
                wr(CORE_CTRL_OFFSET, 8'h02);
                rd(CORE_CTRL_OFFSET, 8'h00);
                wr(CORE_CTRL_OFFSET, 8'h01);
                rd(CORE_CTRL_OFFSET, 8'h01);
                repeat (4) @(posedge clk_sys);
                rd(CORE_CTRL_OFFSET, 8'h00);
                wr(CORE_CTRL_OFFSET, 8'h01);
                @(posedge clk_sys) irq_request <= 19'h00001;
                repeat (4) @(negedge clk_sys)
                    chk({11'h000, dispatch.valid}, 12'h000);
                wait_chk(12'h001, 12'h000);
                wr(CORE_CTRL_OFFSET, 8'h01);
                wr(CORE_CTRL_OFFSET, 8'h02);
                rd(CORE_CTRL_OFFSET, 8'h02);
                chk(reset_vector, 12'h000);
                slow <= 1'b1;
            end
        end
        @(posedge clk_sys) nrst <= 1'b0;
        boot_reset_fuse <= 1'b0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1 chk(reset_vector, BOOT);
        close_out();
    end
endmodule // interrupt_vector_dispatch_tb

// ---- sim/ivd_chk.sv ----
/* Port checker for interrupt_vector_dispatch.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module ivd_chk #(
    parameter logic [11:0] BOOT_RESET_ADDR = 12'hC00
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic boot_reset_fuse,
    input wire logic global_irq_enable,
    input wire logic [vector_pkg::SRC_N-1:0] irq_request,
    input wire logic irq_ack,
    input wire vector_pkg::reg_req_type reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic [vector_pkg::ADDR_W-1:0] reset_vector,
    input wire vector_pkg::dispatch_type dispatch
);
    import vector_pkg::*;
    logic [SRC_N-1:0] req_d;
    logic [11:0] off;
    assign off = {7'h00, dispatch.index} + 12'h001;
    always_ff @(posedge clk_sys) req_d <= irq_request;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence s_unlock;
        reg_req.wr && reg_req.addr == CORE_CTRL_OFFSET && reg_req.wdata[0];
    endsequence
    sequence s_ctrl_rd;
        reg_req.rd && reg_req.addr == CORE_CTRL_OFFSET;
    endsequence
    property p_rst_vec;
        $past(nrst) && $stable(boot_reset_fuse) |-> reset_vector ==
            (boot_reset_fuse ? RESET_ADDR : BOOT_RESET_ADDR);
    endproperty
    property p_vec_addr;
        dispatch.valid |->
            dispatch.addr == off || dispatch.addr == off + BOOT_RESET_ADDR;
    endproperty
    property p_hold;
        dispatch.valid && !irq_ack |=> dispatch.valid && $stable(dispatch);
    endproperty
    property p_ack;
        dispatch.valid && irq_ack |=> !dispatch.valid;
    endproperty
    property p_cause;
        $rose(dispatch.valid) |->
            req_d[dispatch.index] && $past(global_irq_enable);
    endproperty
    property p_rdata_idle;
        !$past(reg_req.rd) |-> reg_rdata == 8'h00;
    endproperty
    property p_block;
        s_unlock ##1 !reg_req.wr |-> ##1 (!$rose(dispatch.valid)) [*3];
    endproperty
    property p_unlock_rd;
        s_unlock ##1 !reg_req.wr ##1 s_ctrl_rd |=> reg_rdata[UNLOCK_BIT];
    endproperty
    property p_reset_out;
        $rose(nrst) |-> !dispatch.valid && reg_rdata == 8'h00;
    endproperty
    a_rst_vec: assert property (p_rst_vec)
        else $error("reset vector wrong");
    a_vec_addr: assert property (p_vec_addr)
        else $error("vector address wrong");
    a_hold: assert property (p_hold)
        else $error("dispatch not held");
    a_ack: assert property (p_ack)
        else $error("dispatch not cleared");
    a_cause: assert property (p_cause)
        else $error("dispatch without request");
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data without read");
    a_block: assert property (p_block)
        else $error("dispatch in unlock window");
    a_unlock_rd: assert property (p_unlock_rd)
        else $error("unlock bit not set");
    a_reset_out: assert property (p_reset_out)
        else $error("outputs not reset");
endmodule // ivd_chk

bind interrupt_vector_dispatch ivd_chk #(
    .BOOT_RESET_ADDR(BOOT_RESET_ADDR)
) chk_u (.clk_sys(clk_sys), .nrst(nrst), .boot_reset_fuse(boot_reset_fuse),
    .global_irq_enable(global_irq_enable), .irq_request(irq_request),
    .irq_ack(irq_ack), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reset_vector(reset_vector), .dispatch(dispatch));
